// ---- hdl/dsss_rate_select.v ----
`timescale 1ns/10ps
`default_nettype none
`include "dsss_rate_select_consts.vh"

module dsss_rate_select (
  input  wire       clk_in,
  input  wire       reset_in,
  input  wire       reg_write_in,
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  output reg  [7:0] reg_rdata_out,
  output reg  [6:0] chips_per_code_out,
  output reg  [1:0] bits_per_code_out,
  output reg  [3:0] oversample_out,
  output reg        high_sensitivity_out,
  output reg        dual_code_enable_out,
  output reg  [2:0] throughput_factor_out,
  output reg        config_invalid_out
);

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  // Reserved bits are not stored, so they always read back as zero.
  localparam [7:0] config_addr = `RATE_CONFIG_ADDR;
  localparam [7:0] used_mask   = `RATE_USED_MASK;
  localparam [7:0] reset_image = `RATE_CONFIG_RESET;
  localparam       field_count = 3;

  wire                   hit;
  wire [field_count-1:0] rate_config;

  assign hit = reg_write_in && (reg_addr_in == config_addr);

  // One storage bit per field, so a new field only widens the loop.
  genvar field_idx;
  generate
    for (field_idx = 0; field_idx < field_count; field_idx = field_idx + 1) begin : field_store
      reg field_reg;

      always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
          field_reg <= reset_image[field_idx];
        end else if (hit) begin
          field_reg <= reg_wdata_in[field_idx] & used_mask[field_idx];
        end
      end

      assign rate_config[field_idx] = field_reg;
    end
  endgenerate

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire short_code;
  wire double_rate;
  wire sample_high;

  assign short_code  = rate_config[`CODE_WIDTH_BIT];
  assign double_rate = rate_config[`DATA_RATE_BIT];
  assign sample_high = rate_config[`SAMPLE_RATE_BIT];

  reg [6:0] chips_next;
  reg [1:0] bits_next;
  reg [3:0] over_next;
  reg [2:0] thru_next;
  reg       sens_next;
  reg       invalid_next;

  // Every combination is spelled out so the illegal ones are easy to audit.
  // Invalid settings are flagged rather than refused, so software sees them.
  always @* begin
    chips_next   = `CHIPS_LONG;
    bits_next    = `BITS_SINGLE;
    over_next    = `OVERSAMPLE_LOW;
    thru_next    = `THROUGHPUT_BASE;
    sens_next    = 1'b0;
    invalid_next = 1'b0;
    case ({short_code, double_rate, sample_high})
      3'h0: begin
        chips_next   = `CHIPS_LONG;
        bits_next    = `BITS_SINGLE;
        over_next    = `OVERSAMPLE_LOW;
        thru_next    = `THROUGHPUT_BASE;
        sens_next    = 1'b0;
        invalid_next = 1'b0;
      end
      3'h1: begin
        // Long codes make the sample bit a don't-care.
        chips_next   = `CHIPS_LONG;
        bits_next    = `BITS_SINGLE;
        over_next    = `OVERSAMPLE_LOW;
        thru_next    = `THROUGHPUT_BASE;
        sens_next    = 1'b0;
        invalid_next = 1'b1;
      end
      3'h2: begin
        // A long code cannot be split, so it still carries one bit.
        chips_next   = `CHIPS_LONG;
        bits_next    = `BITS_SINGLE;
        over_next    = `OVERSAMPLE_LOW;
        thru_next    = `THROUGHPUT_BASE;
        sens_next    = 1'b0;
        invalid_next = 1'b1;
      end
      3'h3: begin
        chips_next   = `CHIPS_LONG;
        bits_next    = `BITS_SINGLE;
        over_next    = `OVERSAMPLE_LOW;
        thru_next    = `THROUGHPUT_BASE;
        sens_next    = 1'b0;
        invalid_next = 1'b1;
      end
      3'h4: begin
        chips_next   = `CHIPS_SHORT;
        bits_next    = `BITS_SINGLE;
        over_next    = `OVERSAMPLE_LOW;
        thru_next    = `THROUGHPUT_DOUBLE;
        sens_next    = 1'b0;
        invalid_next = 1'b0;
      end
      3'h5: begin
        // Only short codes at normal rate may use 12x sampling.
        chips_next   = `CHIPS_SHORT;
        bits_next    = `BITS_SINGLE;
        over_next    = `OVERSAMPLE_HIGH;
        thru_next    = `THROUGHPUT_DOUBLE;
        sens_next    = 1'b1;
        invalid_next = 1'b0;
      end
      3'h6: begin
        // Double rate splits the 32-chip code into two 16-chip halves.
        chips_next   = `CHIPS_SHORT;
        bits_next    = `BITS_DOUBLE;
        over_next    = `OVERSAMPLE_LOW;
        thru_next    = `THROUGHPUT_QUAD;
        sens_next    = 1'b0;
        invalid_next = 1'b0;
      end
      3'h7: begin
        // Double rate makes the sample bit a don't-care.
        chips_next   = `CHIPS_SHORT;
        bits_next    = `BITS_DOUBLE;
        over_next    = `OVERSAMPLE_LOW;
        thru_next    = `THROUGHPUT_QUAD;
        sens_next    = 1'b0;
        invalid_next = 1'b1;
      end
      default: begin
        chips_next   = `CHIPS_LONG;
        bits_next    = `BITS_SINGLE;
        over_next    = `OVERSAMPLE_LOW;
        thru_next    = `THROUGHPUT_BASE;
        sens_next    = 1'b0;
        invalid_next = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= reset_image;
    end else if (reg_addr_in == config_addr) begin
      reg_rdata_out <= {5'h00, rate_config};
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      chips_per_code_out <= `CHIPS_LONG;
    end else begin
      chips_per_code_out <= chips_next;
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      bits_per_code_out <= `BITS_SINGLE;
    end else begin
      bits_per_code_out <= bits_next;
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      oversample_out <= `OVERSAMPLE_LOW;
    end else begin
      oversample_out <= over_next;
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      high_sensitivity_out <= 1'b0;
    end else begin
      high_sensitivity_out <= sens_next;
    end
  end

  // With 12x at normal rate the second correlator is given up.
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      dual_code_enable_out <= 1'b1;
    end else begin
      dual_code_enable_out <= !sens_next;
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      throughput_factor_out <= `THROUGHPUT_BASE;
    end else begin
      throughput_factor_out <= thru_next;
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      config_invalid_out <= 1'b0;
    end else begin
      config_invalid_out <= invalid_next;
    end
  end

endmodule
`default_nettype wire

// ---- hdl/dsss_rate_select_consts.vh ----
`ifndef DSSS_RATE_SELECT_CONSTS_VH
`define DSSS_RATE_SELECT_CONSTS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define RATE_CONFIG_ADDR     8'h04
`define RATE_CONFIG_RESET    8'h00
`define RATE_USED_MASK       8'h07

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CODE_WIDTH_BIT       2
`define DATA_RATE_BIT        1
`define SAMPLE_RATE_BIT      0

// ----------------------------------------
// Derived figures
// ----------------------------------------
`define CHIPS_LONG           7'd64
`define CHIPS_SHORT          7'd32
`define OVERSAMPLE_LOW       4'd6
`define OVERSAMPLE_HIGH      4'd12
`define THROUGHPUT_BASE      3'd1
`define THROUGHPUT_DOUBLE    3'd2
`define THROUGHPUT_QUAD      3'd4
`define BITS_SINGLE          2'd1
`define BITS_DOUBLE          2'd2

`endif

// ---- verif/dsss_rate_select_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module dsss_rate_select_properties (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic       reg_write_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [6:0] chips_per_code_out,
  input wire logic [1:0] bits_per_code_out,
  input wire logic [3:0] oversample_out,
  input wire logic       high_sensitivity_out,
  input wire logic       dual_code_enable_out,
  input wire logic [2:0] throughput_factor_out,
  input wire logic       config_invalid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire logic [2:0] d = reg_wdata_in[2:0];
  // A write lands in the register at once and reaches the outputs one edge later.
  sequence wr_s;
    reg_write_in && reg_addr_in == 8'h04 ##2 1;
  endsequence
  chip_count_a: assert property (wr_s |->
    chips_per_code_out == ($past(d[2], 2) ? 7'd32 : 7'd64)) else $error("chip count wrong");
  rate_gain_a: assert property (wr_s |-> throughput_factor_out ==
    (!$past(d[2],2) ? 3'd1 : $past(d[1],2) ? 3'd4 : 3'd2)) else $error("throughput wrong");
  over_factor_a: assert property (wr_s |->
    oversample_out == ($past(d, 2) == 3'd5 ? 4'd12 : 4'd6)) else $error("oversampling wrong");
  sens_match_a: assert property (high_sensitivity_out == (oversample_out == 4'd12))
    else $error("sensitivity wrong");
  one_code_a: assert property (dual_code_enable_out != high_sensitivity_out)
    else $error("code count wrong");
  single_code_a: assert property (wr_s |->
    dual_code_enable_out == ($past(d, 2) != 3'd5)) else $error("dual code setting wrong");
  bits_split_a: assert property (wr_s |->
    bits_per_code_out == ($past(d[2:1], 2) == 2'b11 ? 2'd2 : 2'd1)) else $error("bits wrong");
  bad_combo_a: assert property (wr_s |->
    config_invalid_out == ($past(d, 2) inside {3'd1, 3'd2, 3'd3, 3'd7}))
    else $error("invalid flag wrong");
endmodule
`default_nettype wire

// ---- verif/host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module host_model(
  input  wire logic       clk_in,
  output var  logic       write_out = 1'b0,
  output var  logic [7:0] addr_out = 8'h00,
  output var  logic [7:0] data_out = 8'h00);
  task wr(input logic [7:0] a, input logic [7:0] v, input bit legal, output logic [7:0] sent);
    sent = v;
    if (legal) begin
      sent[7:3] = 5'h00;
      // An invalid mix loses its sample bit, and a long code also loses double rate.
      if (sent[2:0] inside {3'h1, 3'h2, 3'h3, 3'h7}) begin
        sent[2:0] = {sent[2], sent[2] & sent[1], 1'b0};
      end
    end
    @(posedge clk_in);
    write_out <= 1'b1;
    addr_out  <= a;
    data_out  <= sent;
    @(posedge clk_in);
    // Inverted data after release keeps a stale byte from passing as a new write.
    write_out <= 1'b0;
    addr_out  <= 8'h04;
    data_out  <= ~sent;
  endtask
endmodule
`default_nettype wire

// ---- verif/dsss_rate_select_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module dsss_rate_select_tb;
  logic clk_in = 0, reset_in = 1, reg_write_in, high_sensitivity_out, dual_code_enable_out;
  logic config_invalid_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, a, v, sent;
  bit legal;
  logic [6:0] chips_per_code_out;
  logic [1:0] bits_per_code_out;
  logic [3:0] oversample_out;
  logic [2:0] throughput_factor_out, f = 3'd0;
  int fail_count = 0, n_tests = 0;
  always #5 clk_in = ~clk_in;
  host_model H(.clk_in(clk_in), .write_out(reg_write_in), .addr_out(reg_addr_in),
    .data_out(reg_wdata_in));
  dsss_rate_select DUT(.clk_in(clk_in), .reset_in(reset_in), .reg_write_in(reg_write_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .chips_per_code_out(chips_per_code_out), .bits_per_code_out(bits_per_code_out),
    .oversample_out(oversample_out), .high_sensitivity_out(high_sensitivity_out),
    .dual_code_enable_out(dual_code_enable_out),
    .throughput_factor_out(throughput_factor_out), .config_invalid_out(config_invalid_out));
  // 12x needs a short code, normal rate and the sample bit set, that is fields 101.
  function automatic logic [26:0] ex(input logic [2:0] c);
    ex = {c==3'd5 ? 4'd12 : 4'd6, c[2] ? 7'd32 : 7'd64, c[2:1]==2'b11 ? 2'd2 : 2'd1,
      !c[2] ? 3'd1 : c[1] ? 3'd4 : 3'd2, c inside {1,2,3,7}, c==3'd5, c!=3'd5, 5'd0, c};
  endfunction
  task print_verdict;
    $display("tests %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(71427));
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int i = -1; i < 48; i++) begin
      if (i >= 0) begin
        v = (i < 8) ? {5'h1f, i[2:0]} : 8'($urandom);
        a = (i >= 8 && $urandom % 4 == 0) ? 8'h05 : 8'h04;
        // Corner cases break the host rules on purpose; random writes keep them half the time.
        legal = (i >= 8) && ($urandom % 2 == 1);
        H.wr(a, v, legal, sent);
        if (a == 8'h04) f = sent[2:0];
        repeat (2) @(posedge clk_in);
      end
      #1 n_tests++;
      if ({oversample_out, chips_per_code_out, bits_per_code_out, throughput_factor_out,
        config_invalid_out, high_sensitivity_out, dual_code_enable_out,
        reg_rdata_out} !== ex(f)) begin
        fail_count++;
        $display("[FAIL] %0t outputs differ for fields %b", $time, f);
      end
      $display("test %0d done", i);
    end
    print_verdict();
  end
endmodule
bind dsss_rate_select dsss_rate_select_properties P(.clk_in(clk_in), .reset_in(reset_in),
  .reg_write_in(reg_write_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .chips_per_code_out(chips_per_code_out), .bits_per_code_out(bits_per_code_out),
  .oversample_out(oversample_out), .high_sensitivity_out(high_sensitivity_out),
  .dual_code_enable_out(dual_code_enable_out), .throughput_factor_out(throughput_factor_out),
  .config_invalid_out(config_invalid_out));
`default_nettype wire
